// ### hdl/eab_pkg.sv
// Purpose: Shared constants and types for the extend-add and bitfield unit
// Assumes: 32-bit datapath, operation codes supplied by the decoder
// Notes:   Operation encoding is local to this unit
package eab_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned HALF_W    = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned POS_W     = 5;
  localparam int unsigned WIDTH_W   = 6;
  localparam int unsigned ROT_W     = 2;
  localparam int unsigned ROT_STEP  = 8;
  localparam int unsigned REG_IDX_W = 4;
  localparam logic [REG_IDX_W-1:0] SP_IDX = 4'hd;
  localparam logic [REG_IDX_W-1:0] PC_IDX = 4'hf;
  localparam logic [DATA_W-1:0]    RESULT_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    signed_byte_extend_add,
    unsigned_byte_extend_add,
    signed_half_extend_add,
    unsigned_half_extend_add,
    dual_signed_byte_extend_add,
    dual_unsigned_byte_extend_add,
    field_clear_op,
    field_insert_op,
    signed_field_extract_op,
    unsigned_field_extract_op
  } eab_op_e;

endpackage : eab_pkg

// ### hdl/eab_field_mask.sv
// Purpose: Builds a contiguous field mask from a low position and a width
// Assumes: Position 0..31, width 1..32-position
// Notes:   Purely combinational
`timescale 1ns/1ps
module eab_field_mask
  import eab_pkg::*;
(
  input  wire logic [POS_W-1:0]   low_pos,
  input  wire logic [WIDTH_W-1:0] field_width,
  output logic      [DATA_W-1:0]  mask,
  output logic      [DATA_W-1:0]  low_mask
);

  // Low mask of field_width ones, then shifted into place
  always_comb
  begin
    for (int i = 0; i < DATA_W; i++)
    begin
      low_mask[i] = (i < int'(field_width));
    end
    mask = low_mask << low_pos;
  end

endmodule : eab_field_mask

// ### hdl/eab_unit.sv
// Purpose: Rotate, extend and add plus bitfield clear, insert and extract
// Assumes: Operands from decoder and register file, result registered
// Notes:
// Notes on behaviour
// - Rotate second source operand right by 0, 8, 16 or 24 bits.
// - Without rotation option, pass second source operand unrotated.
// - Signed byte form sign-extends rotated bits 7..0 to 32 bits.
// - Unsigned byte form zero-extends rotated bits 7..0 to 32 bits.
// - Signed half form sign-extends rotated bits 15..0 to 32 bits.
// - Unsigned half form zero-extends rotated bits 15..0 to 32 bits.
// - Dual signed form sign-extends bytes 7..0 and 23..16 to 16 bits each.
// - Dual unsigned form zero-extends bytes 7..0 and 23..16 to 16 bits.
// - Add to whole first operand, or halfwise for dual forms; write result.
// - None of these operations change the condition flags.
// - Field clear zeroes the span, keeps other destination bits.
// - Field insert puts source low bits into span, keeps other bits.
// - Signed extract right-aligns span and sign-extends from its top bit.
// - Unsigned extract right-aligns span and zero-fills upper bits.
`timescale 1ns/1ps
module eab_unit
  import eab_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 clk_en,
  input  wire logic                 issue,
  input  wire eab_op_e              op,
  input  wire logic                 cond_pass,
  input  wire logic                 rotate_amount_option,
  input  wire logic [ROT_W-1:0]     rot_sel,
  input  wire logic [DATA_W-1:0]    first_source_operand,
  input  wire logic [DATA_W-1:0]    second_source_operand,
  input  wire logic [DATA_W-1:0]    dest_old,
  input  wire logic [POS_W-1:0]     low_pos,
  input  wire logic [WIDTH_W-1:0]   field_width,
  input  wire logic [REG_IDX_W-1:0] dest_idx,
  input  wire logic [REG_IDX_W-1:0] src1_idx,
  input  wire logic [REG_IDX_W-1:0] src2_idx,
  input  wire logic [3:0]           flags_in,
  output logic                      result_we,
  output logic      [REG_IDX_W-1:0] result_idx,
  output logic      [DATA_W-1:0]    result,
  output logic      [3:0]           flags_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                 we;
    logic [REG_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    data;
    logic [3:0]           flags;
  } eab_state_s;

  eab_state_s state;
  eab_state_s next_state;

  logic [DATA_W-1:0] rotated;
  logic [DATA_W-1:0] ext;
  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] field_val;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] low_mask;
  logic [DATA_W-1:0] shifted;
  logic [POS_W-1:0]  top_pos;

  function automatic logic is_dual(input eab_op_e o);
    is_dual = (o == dual_signed_byte_extend_add) ||
              (o == dual_unsigned_byte_extend_add);
  endfunction : is_dual

  eab_field_mask u_mask (
    .low_pos     (low_pos),
    .field_width (field_width),
    .mask        (mask),
    .low_mask    (low_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  always_comb
  begin
    if (rotate_amount_option)
    begin
      rotated = (second_source_operand >> (rot_sel * ROT_STEP)) |
                (second_source_operand << (DATA_W - rot_sel * ROT_STEP));
      if (rot_sel == '0)
      begin
        rotated = second_source_operand;
      end
    end
    else
    begin
      rotated = second_source_operand;
    end
    unique case (op)
      signed_byte_extend_add:   ext = {{24{rotated[7]}}, rotated[7:0]};
      unsigned_byte_extend_add: ext = {24'h00_0000, rotated[7:0]};
      signed_half_extend_add:   ext = {{16{rotated[15]}}, rotated[15:0]};
      unsigned_half_extend_add: ext = {16'h0000, rotated[15:0]};
      dual_signed_byte_extend_add:
        ext = {{8{rotated[23]}}, rotated[23:16], {8{rotated[7]}}, rotated[7:0]};
      dual_unsigned_byte_extend_add:
        ext = {8'h00, rotated[23:16], 8'h00, rotated[7:0]};
      default: ext = RESULT_RST;
    endcase
    if (is_dual(op))
    begin
      sum = {first_source_operand[31:16] + ext[31:16],
             first_source_operand[15:0] + ext[15:0]};
    end
    else
    begin
      sum = first_source_operand + ext;
    end
    shifted = (first_source_operand >> low_pos) & low_mask;
    top_pos = 5'(field_width - 6'h01);
    unique case (op)
      field_clear_op:  field_val = dest_old & ~mask;
      field_insert_op:
        field_val = (dest_old & ~mask) | ((first_source_operand << low_pos) & mask);
      signed_field_extract_op:
        field_val = shifted[top_pos] ? (shifted | ~low_mask) : shifted;
      unsigned_field_extract_op: field_val = shifted;
      default: field_val = sum;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_state = state;
    next_state.we = issue && cond_pass;
    if (issue && cond_pass)
    begin
      next_state.idx  = dest_idx;
      next_state.data = field_val;
    end
    next_state.flags = flags_in;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  assign result_we  = state.we;
  assign result_idx = state.idx;
  assign result     = state.data;
  assign flags_out  = state.flags;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_issue_pass;
    issue && cond_pass && clk_en;
  endsequence

  property p_cond_false_no_write;
    @(posedge mclk) disable iff (!rst_b)
      (issue && !cond_pass && clk_en) |=> !result_we;
  endproperty
  a_cond_false_no_write: assert property (p_cond_false_no_write)
    else $error("write on failed condition");

  property p_flags_kept;
    @(posedge mclk) disable iff (!rst_b)
      clk_en |=> flags_out == $past(flags_in);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags altered");

  property p_ubyte_add;
    @(posedge mclk) disable iff (!rst_b)
      (s_issue_pass and (op == unsigned_byte_extend_add) && !rotate_amount_option)
      |=> result == $past(first_source_operand) + {24'h00_0000, $past(second_source_operand[7:0])};
  endproperty
  a_ubyte_add: assert property (p_ubyte_add)
    else $error("unsigned byte add wrong");

  property p_shalf_add;
    @(posedge mclk) disable iff (!rst_b)
      (s_issue_pass and (op == signed_half_extend_add) && rotate_amount_option && rot_sel == 2'h2)
      |=> result == $past(first_source_operand) +
          {{16{$past(second_source_operand[31])}}, $past(second_source_operand[31:16])};
  endproperty
  a_shalf_add: assert property (p_shalf_add)
    else $error("signed half add with rotate wrong");

  property p_sbyte_rot8;
    @(posedge mclk) disable iff (!rst_b)
      (s_issue_pass and (op == signed_byte_extend_add) && rotate_amount_option && rot_sel == 2'h1)
      |=> result == $past(first_source_operand) +
          {{24{$past(second_source_operand[15])}}, $past(second_source_operand[15:8])};
  endproperty
  a_sbyte_rot8: assert property (p_sbyte_rot8)
    else $error("rotate by eight wrong");

  property p_dual_low;
    @(posedge mclk) disable iff (!rst_b)
      (s_issue_pass and (op == dual_unsigned_byte_extend_add) && !rotate_amount_option)
      |=> result[15:0] == 16'($past(first_source_operand[15:0]) +
          {8'h00, $past(second_source_operand[7:0])});
  endproperty
  a_dual_low: assert property (p_dual_low)
    else $error("dual low half wrong");

  property p_clear_span;
    @(posedge mclk) disable iff (!rst_b)
      (s_issue_pass and (op == field_clear_op))
      |=> ((result & $past(mask)) == '0) &&
          ((result & ~$past(mask)) == ($past(dest_old) & ~$past(mask)));
  endproperty
  a_clear_span: assert property (p_clear_span)
    else $error("field clear wrong");

  property p_uextract;
    @(posedge mclk) disable iff (!rst_b)
      (s_issue_pass and (op == unsigned_field_extract_op))
      |=> (result & ~$past(low_mask)) == '0;
  endproperty
  a_uextract: assert property (p_uextract)
    else $error("unsigned extract upper bits set");

endmodule : eab_unit

// ### testbench/eab_regfile_model.sv
// Purpose: Register file model facing the unit
// Assumes: Write on result_we, combinational read
// Notes:   Reset contents are a fixed pattern
`timescale 1ns/1ps
module eab_regfile_model
  import eab_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 result_we,
  input  wire logic [REG_IDX_W-1:0] result_idx,
  input  wire logic [DATA_W-1:0]    result,
  input  wire logic [REG_IDX_W-1:0] rd_idx,
  output logic      [DATA_W-1:0]    rd_data
);
  logic [DATA_W-1:0] regs [16];
  // Write back of results
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (!rst_b)
        regs[i] <= 32'h1111_1111 * i;
    end
    if (rst_b && result_we)
      regs[result_idx] <= result;
  end
  assign rd_data = regs[rd_idx];
endmodule : eab_regfile_model

// ### testbench/eab_unit_tb.sv
// Purpose: Self-checking bench for the extend-add and bitfield unit
// Assumes: One cycle latency, back to back issue
// Notes:   Random stimulus from a fixed-seed shift register
`timescale 1ns/1ps
module eab_unit_tb
  import eab_pkg::*;
;
  logic        mclk, rst_b, clk_en, issue, cond_pass, rotate_amount_option, result_we;
  logic [1:0]  rot_sel;
  eab_op_e     op;
  logic [31:0] a, b, dest_old, result, e_res, rnd;
  logic [4:0]  low_pos;
  logic [5:0]  field_width;
  logic [3:0]  dest_idx, src1_idx, src2_idx, flags_in, result_idx, flags_out, e_idx, e_fl;
  logic        e_we;
  int          err_count, total_checks;
  eab_unit DUT (.mclk, .rst_b, .clk_en, .issue, .op, .cond_pass, .rotate_amount_option,
    .rot_sel, .first_source_operand(a), .second_source_operand(b), .dest_old, .low_pos,
    .field_width, .dest_idx, .src1_idx, .src2_idx, .flags_in, .result_we, .result_idx,
    .result, .flags_out);
  eab_regfile_model rf (.mclk, .rst_b, .result_we, .result_idx, .result,
    .rd_idx(dest_idx), .rd_data(dest_old));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [3:0] pick(logic [3:0] x);
    return (x == SP_IDX || x == PC_IDX) ? x - 4'h1 : x;
  endfunction : pick
  function automatic logic [31:0] ref_calc(int o, logic ro, logic [1:0] rs,
    logic [31:0] x, logic [31:0] y, logic [31:0] d, int lp, int w);
    logic [31:0] r, m, f;
    r = ro ? ((y >> (8 * rs)) | (y << (32 - 8 * rs))) : y;
    m = (w == 32) ? 32'hffff_ffff : ((32'h0000_0001 << w) - 1);
    f = (x >> lp) & m;
    case (o)
      0: return x + {{24{r[7]}}, r[7:0]};
      1: return x + {24'h00_0000, r[7:0]};
      2: return x + {{16{r[15]}}, r[15:0]};
      3: return x + {16'h0000, r[15:0]};
      4: return {x[31:16] + {{8{r[23]}}, r[23:16]}, x[15:0] + {{8{r[7]}}, r[7:0]}};
      5: return {x[31:16] + {8'h00, r[23:16]}, x[15:0] + {8'h00, r[7:0]}};
      6: return d & ~(m << lp);
      7: return (d & ~(m << lp)) | ((x & m) << lp);
      8: return f | (f[w-1] ? ~m : 32'h0000_0000);
      default: return f;
    endcase
  endfunction : ref_calc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(int o, logic ro, logic [1:0] rs, logic [31:0] x, logic [31:0] y,
    int lp, int w, logic cp, logic iss, logic en);
    @(posedge mclk);
    op <= eab_op_e'(o);
    rotate_amount_option <= ro;
    rot_sel <= rs;
    a <= x;
    b <= y;
    low_pos <= lp[4:0];
    field_width <= w[5:0];
    cond_pass <= cp;
    issue <= iss;
    clk_en <= en;
    dest_idx <= pick(x[31:28] ^ y[3:0]);
    src1_idx <= pick(x[3:0]);
    src2_idx <= pick(y[7:4]);
    flags_in <= y[31:28] ^ x[7:4];
    #1;
    chk(result_we, e_we);
    chk(result, e_res);
    chk(result_idx, e_idx);
    chk(flags_out, e_fl);
    if (en)
    begin
      e_fl = flags_in;
      e_we = iss & cp;
      if (iss & cp)
      begin
        e_res = ref_calc(o, ro, rs, x, y, dest_old, lp, w);
        e_idx = dest_idx;
      end
    end
  endtask : step
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int          lp;
    int          w;
    logic [31:0] y;
    static int   lps [5] = '{31, 0, 0, 8, 20};
    static int   ws [5] = '{1, 32, 31, 12, 4};
    {rst_b, clk_en, issue, cond_pass, rotate_amount_option, rot_sel} = '0;
    {a, b, low_pos, field_width, dest_idx, src1_idx, src2_idx, flags_in} = '0;
    op = signed_byte_extend_add;
    {e_we, e_idx, e_fl, e_res} = '0;
    err_count = 0;
    total_checks = 0;
    rnd = 32'h0000_76fa;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    for (int o = 0; o < 6; o++)
      for (int k = 0; k < 8; k++)
        step(o, k[2], k[1:0], 32'h7fff_8001 + o, 32'h80ff_7f81, 0, 1, 1'b1, 1'b1, 1'b1);
    for (int o = 6; o < 10; o++)
      for (int k = 0; k < 5; k++)
        step(o, 1'b0, 2'h0, 32'h80f0_0f81 ^ k, 32'h0000_0000, lps[k], ws[k], 1'b1, 1'b1, 1'b1);
    $display("test directed done");
    for (int n = 0; n < 2000; n++)
    begin
      rnd = lfsr(rnd);
      y = rnd;
      rnd = lfsr(rnd);
      lp = rnd[4:0];
      w = 1 + int'(rnd[10:5]) % (32 - lp);
      step(int'(rnd[31:16]) % 10, rnd[11], rnd[13:12], lfsr(rnd ^ y), y, lp, w,
        rnd[14] | rnd[15], rnd[16] | rnd[17], rnd[18] | rnd[19] | rnd[20]);
    end
    $display("test random done");
    stop_test();
  end
endmodule : eab_unit_tb
